// ---- hdl/hbp_defs.svh ----
`ifndef HBP_DEFS_SVH
`define HBP_DEFS_SVH

// host mode select pin codes
`define HBP_MODE_CODE_ASYNC 3'h0
`define HBP_MODE_CODE_SYNC 3'h1
`define HBP_MODE_CODE_ASYNC_ACK 3'h2

// address field positions
`define HBP_ADDR_W 11
`define HBP_REG_ADDR_MSB 7
`define HBP_CHIP_LSB 8
`define HBP_CHIP_MSB 10

// synchroniser vector layout (inputs from the host pins)
`define HBP_SYN_W 30
`define HBP_SYN_CS 29
`define HBP_SYN_RD 28
`define HBP_SYN_WR 27
`define HBP_SYN_LATCH 26
`define HBP_SYN_HCLK 25
`define HBP_SYN_ADDR_MSB 24
`define HBP_SYN_ADDR_LSB 14
`define HBP_SYN_DATA_MSB 13
`define HBP_SYN_DATA_LSB 6
`define HBP_SYN_MODE_MSB 5
`define HBP_SYN_MODE_LSB 3
`define HBP_SYN_CHIP_MSB 2
`define HBP_SYN_CHIP_LSB 0
// idle pin levels: select, read and write strobes high
`define HBP_SYN_RST {3'h7, 27'h0000000}

// reset values
`define HBP_COMPLETION_RST 1'h1
`define HBP_BYTE_RST 8'h00

// timing
`define HBP_CLK_PERIOD_NS 4
`define HBP_ACK_MAX_NS 150
`define HBP_ACK_MAX_CYC (`HBP_ACK_MAX_NS / `HBP_CLK_PERIOD_NS)
`define HBP_SYNC_STAGES 2

`endif

// ---- hdl/hbp_pkg.sv ----
package hbp_pkg;

    typedef enum logic [1:0] {
        MODE_NONE,
        MODE_ASYNC,
        MODE_SYNC,
        MODE_ASYNC_ACK
    } hbp_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ACCESS,
        ST_CAPTURE,
        ST_DONE,
        ST_HOLD
    } hbp_state_t;

    typedef struct packed {
        hbp_state_t state;
        logic is_read;
        logic hclk_prev;
        logic [7:0] reg_addr;
        logic [7:0] wdata;
        logic reg_wr;
        logic reg_rd;
        logic [7:0] dout;
        logic oe;
        logic done_n;
    } hbp_top_st_t;

    typedef struct packed {
        logic [7:0] held;
    } hbp_latch_st_t;

endpackage

// ---- hdl/hbp_addr_if.sv ----
interface hbp_addr_if;
    logic [7:0] raw_addr;
    logic pin_level;
    logic [7:0] sel_addr;

    modport ctl (
        output raw_addr,
        output pin_level,
        input sel_addr
    );

    modport lat (
        input raw_addr,
        input pin_level,
        output sel_addr
    );
endinterface

// ---- hdl/hbp_sync.sv ----
module hbp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } hbp_sync_st_t;

    hbp_sync_st_t st_reg;
    hbp_sync_st_t st_next;

    // first stage feeds only the second stage
    always_comb begin
        st_next.s1 = i_d;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            st_reg <= {RST, RST};
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end

    assign o_q = st_reg.s2;
endmodule

// ---- hdl/hbp_addr_latch.sv ----
`include "hbp_defs.svh"

module hbp_addr_latch (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    hbp_addr_if.lat a
);
    hbp_pkg::hbp_latch_st_t st_reg;
    hbp_pkg::hbp_latch_st_t st_next;

    // R4: capture on fall
    // the held copy follows while the pin is high, so the falling edge
    // freezes the last transparent value; one path serves all three modes
    always_comb begin
        st_next = st_reg;
        if (a.pin_level) begin
            st_next.held = a.raw_addr;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            st_reg <= '{held: `HBP_BYTE_RST};
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end

    // R3: transparent while high
    assign a.sel_addr = a.pin_level ? a.raw_addr : st_reg.held;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n || !i_ce);

    a_latch_pass_high: assert property ( // R3
        a.pin_level ##1 a.pin_level |-> a.sel_addr == a.raw_addr)
        else $error("address stage not transparent while latch pin high");

    a_latch_hold_low: assert property ( // R4
        $fell(a.pin_level) ##1 !a.pin_level
            |-> a.sel_addr == $past(a.raw_addr, 2))
        else $error("address not held after latch pin fall");
endmodule

// ---- hdl/hbp_host_port.sv ----
`include "hbp_defs.svh"

// Operation
// R1: host drives the 11-bit address and pulls chip select low together.
// R2: all strobes are ignored unless chip select is low.
// R3: in async mode the address stage is transparent while latch pin high.
// R4: falling latch pin captures the address for the rest of the cycle.
// R5: read strobe low marks a read; data bus drivers present the register.
// R6: after read strobe falls, completion goes low with valid read data.
// R7: host ends an async read by raising read strobe after completion.
// R8: host places write data after latching address, before write strobe.
// R9: write strobe low with chip select low makes a write cycle.
// R10: write data is stored before completion is asserted low.
// R11: latch pin tied high keeps the address path transparent.
// R12: in sync mode the address is latched when transfer_start falls.
// R13: in sync mode direction pin high reads, low writes.
// R14: in sync mode transfer_ack_n falls once data is valid or stored.
// R15: host ends a sync cycle by raising the strobe after acknowledge.
// R16: async completion within 150 ns of read strobe.
// R17: async completion within 150 ns of write strobe.
// R18: host waits 30 ns after chip select before any async strobe.
// R19: sync acknowledge within 150 ns of access strobe.
// R20: host lowers chip select no later than transfer_start falls.
// R21: data_ack_n answers data_strobe_n within 150 ns.
// R22: host asserts data_strobe_n 30 ns after select; addr_strobe_n on latch.
// R23: handshake style chosen by the three host_mode_select pins.
// R24: sync mode samples and answers on host_sync_clock edges.
// R25: top three address bits are decoded as a chip select.
// R26: data bus driven only during a selected read with strobe asserted.
// R27: completion released when strobe or chip select returns high.
module hbp_host_port (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic [2:0] i_host_mode_select,
    input wire logic [2:0] i_chip_id,
    input wire logic i_cs_n,
    input wire logic [10:0] i_addr,
    input wire logic i_latch_or_start_pin,
    input wire logic i_rd_strobe_pin,
    input wire logic i_wr_rnw_pin,
    input wire logic i_host_sync_clock,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic o_data_oe,
    output logic o_completion_pin,
    output logic [7:0] o_reg_addr,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [7:0] o_reg_wdata,
    input wire logic [7:0] i_reg_rdata
);
    localparam hbp_pkg::hbp_top_st_t ST_RST = '{
        state: hbp_pkg::ST_IDLE,
        is_read: 1'h0,
        hclk_prev: 1'h0,
        reg_addr: `HBP_BYTE_RST,
        wdata: `HBP_BYTE_RST,
        reg_wr: 1'h0,
        reg_rd: 1'h0,
        dout: `HBP_BYTE_RST,
        oe: 1'h0,
        done_n: `HBP_COMPLETION_RST
    };
    localparam int ACK_BOUND = `HBP_ACK_MAX_CYC - `HBP_SYNC_STAGES;

    function automatic hbp_pkg::hbp_mode_t decode_mode(
        input logic [2:0] code
    );
        hbp_pkg::hbp_mode_t m;
        unique case (code)
            `HBP_MODE_CODE_ASYNC: m = hbp_pkg::MODE_ASYNC;
            `HBP_MODE_CODE_SYNC: m = hbp_pkg::MODE_SYNC;
            `HBP_MODE_CODE_ASYNC_ACK: m = hbp_pkg::MODE_ASYNC_ACK;
            default: m = hbp_pkg::MODE_NONE;
        endcase
        return m;
    endfunction

    hbp_pkg::hbp_top_st_t st_reg;
    hbp_pkg::hbp_top_st_t st_next;

    logic [`HBP_SYN_W-1:0] raw_vec;
    logic [`HBP_SYN_W-1:0] syn_vec;
    logic cs_q;
    logic rd_q;
    logic wr_q;
    logic hclk_q;
    logic [7:0] data_q;
    logic chip_hit;
    logic hclk_rise;
    logic tick;
    logic strobe_on;
    logic sel_ok;
    logic req_live;
    hbp_pkg::hbp_mode_t mode_q;

    // every host pin is asynchronous to i_ref_clk
    assign raw_vec = {i_cs_n, i_rd_strobe_pin, i_wr_rnw_pin,
                      i_latch_or_start_pin, i_host_sync_clock, i_addr,
                      i_data, i_host_mode_select, i_chip_id};

    hbp_sync #(
        .W(`HBP_SYN_W),
        .RST(`HBP_SYN_RST)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_d(raw_vec),
        .o_q(syn_vec)
    );

    assign cs_q = syn_vec[`HBP_SYN_CS];
    assign rd_q = syn_vec[`HBP_SYN_RD];
    assign wr_q = syn_vec[`HBP_SYN_WR];
    assign hclk_q = syn_vec[`HBP_SYN_HCLK];
    assign data_q = syn_vec[`HBP_SYN_DATA_MSB:`HBP_SYN_DATA_LSB];

    // R23: mode from pins
    assign mode_q = decode_mode(
        syn_vec[`HBP_SYN_MODE_MSB:`HBP_SYN_MODE_LSB]);

    // R25: upper address decode
    assign chip_hit = syn_vec[`HBP_SYN_ADDR_LSB + `HBP_CHIP_MSB:
                              `HBP_SYN_ADDR_LSB + `HBP_CHIP_LSB]
                      == syn_vec[`HBP_SYN_CHIP_MSB:`HBP_SYN_CHIP_LSB];

    // R24: host clock timing
    // sync mode accepts a strobe and asserts completion only on host clock rising edges
    assign hclk_rise = hclk_q & ~st_reg.hclk_prev;
    assign tick = (mode_q == hbp_pkg::MODE_SYNC) ? hclk_rise : 1'h1;

    // R9: either async strobe
    assign strobe_on = (mode_q == hbp_pkg::MODE_ASYNC) ? (!rd_q || !wr_q)
                                                       : !rd_q;
    // R2: select gates strobes
    assign sel_ok = !cs_q && chip_hit && (mode_q != hbp_pkg::MODE_NONE);
    assign req_live = sel_ok && strobe_on;

    hbp_addr_if a_if ();

    assign a_if.raw_addr = syn_vec[`HBP_SYN_ADDR_LSB + `HBP_REG_ADDR_MSB:
                                   `HBP_SYN_ADDR_LSB];
    // R11: latch pin may stay high
    assign a_if.pin_level = syn_vec[`HBP_SYN_LATCH];

    // R12: start fall latches
    hbp_addr_latch u_latch (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .a(a_if.lat)
    );

    always_comb begin
        st_next = st_reg;
        st_next.hclk_prev = hclk_q;
        st_next.reg_wr = 1'h0;
        st_next.reg_rd = 1'h0;
        // R26: drivers off early
        if (!req_live) begin
            st_next.oe = 1'h0;
        end
        unique case (st_reg.state)
            hbp_pkg::ST_IDLE: begin
                if (tick && req_live) begin
                    // R13: direction pin
                    if (mode_q == hbp_pkg::MODE_ASYNC) begin
                        st_next.is_read = !rd_q;
                    end else begin
                        st_next.is_read = wr_q;
                    end
                    st_next.reg_addr = a_if.sel_addr;
                    st_next.wdata = data_q;
                    st_next.state = hbp_pkg::ST_ACCESS;
                end
            end
            hbp_pkg::ST_ACCESS: begin
                // R10: store before done
                st_next.reg_rd = st_reg.is_read;
                st_next.reg_wr = !st_reg.is_read;
                st_next.state = hbp_pkg::ST_CAPTURE;
            end
            hbp_pkg::ST_CAPTURE: begin
                // R5: present read data
                if (st_reg.is_read) begin
                    st_next.dout = i_reg_rdata;
                    st_next.oe = req_live;
                end
                st_next.state = hbp_pkg::ST_DONE;
            end
            hbp_pkg::ST_DONE: begin
                // an aborted strobe gets no answer; the write has landed
                if (!req_live) begin
                    st_next.state = hbp_pkg::ST_IDLE;
                end else if (tick) begin
                    // R6: completion low
                    // R14: ack on host edge
                    st_next.done_n = 1'h0;
                    st_next.state = hbp_pkg::ST_HOLD;
                end
            end
            hbp_pkg::ST_HOLD: begin
                // R27: release on strobe end
                if (!req_live) begin
                    st_next.done_n = 1'h1;
                    st_next.oe = 1'h0;
                    st_next.state = hbp_pkg::ST_IDLE;
                end
            end
            default: begin
                st_next = ST_RST;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            st_reg <= ST_RST;
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end

    assign o_data = st_reg.dout;
    assign o_data_oe = st_reg.oe;
    assign o_completion_pin = st_reg.done_n;
    assign o_reg_addr = st_reg.reg_addr;
    assign o_reg_wr = st_reg.reg_wr;
    assign o_reg_rd = st_reg.reg_rd;
    assign o_reg_wdata = st_reg.wdata;

    // R16 R17 R19 R21: answer time
    // counts cycles from the synchronised strobe to completion
    // frozen with the rest of the state while the enable is low
    logic [5:0] wait_cnt;
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            wait_cnt <= 6'h00;
        end else if (i_ce) begin
            if (req_live && st_reg.done_n) begin
                wait_cnt <= wait_cnt + 6'h01;
            end else begin
                wait_cnt <= 6'h00;
            end
        end
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n || !i_ce);

    a_cs_gate_idle: assert property ( // R2
        st_reg.state == hbp_pkg::ST_IDLE && cs_q
            |=> st_reg.state == hbp_pkg::ST_IDLE)
        else $error("access started without chip select");

    a_chip_decode: assert property ( // R25
        st_reg.state == hbp_pkg::ST_IDLE && !chip_hit
            |=> st_reg.state == hbp_pkg::ST_IDLE)
        else $error("access started for another chip");

    a_mode_select: assert property ( // R23
        st_reg.state == hbp_pkg::ST_IDLE && mode_q == hbp_pkg::MODE_NONE
            |=> st_reg.state == hbp_pkg::ST_IDLE)
        else $error("access started with undefined mode");

    a_ack_bound: assert property ( // R16
        wait_cnt <= ACK_BOUND)
        else $error("completion later than 150 ns");

    a_write_first: assert property ( // R10
        o_reg_wr |-> o_completion_pin ##1 o_completion_pin)
        else $error("completion before write stored");

    // sync mode waits a host clock edge in done, so only fixed-step modes
    a_read_data_on: assert property ( // R6
        $fell(o_completion_pin) && st_reg.is_read
            && mode_q != hbp_pkg::MODE_SYNC
            |-> o_data_oe && $past(o_reg_rd, 2))
        else $error("read completion without data");

    a_read_ack_data: assert property ( // R14
        $fell(o_completion_pin) && st_reg.is_read |-> o_data_oe)
        else $error("read acknowledge without data drivers");

    a_read_capture: assert property ( // R5
        o_reg_rd |=> o_data == $past(i_reg_rdata))
        else $error("read data not taken from register");

    a_oe_only_read: assert property ( // R26
        o_data_oe |-> st_reg.is_read && $past(req_live))
        else $error("data bus driven outside a read");

    a_release_done: assert property ( // R27
        !o_completion_pin && !req_live
            |=> o_completion_pin && !o_data_oe)
        else $error("completion not released");

    a_sync_tick: assert property ( // R24
        $fell(o_completion_pin) && mode_q == hbp_pkg::MODE_SYNC
            |-> $past(hclk_rise))
        else $error("sync ack not on host clock edge");

    a_dir_select: assert property ( // R13
        st_reg.state == hbp_pkg::ST_IDLE && tick && req_live
            && mode_q == hbp_pkg::MODE_SYNC
            |=> st_reg.is_read == $past(wr_q))
        else $error("sync direction wrong");

    c_async_read: cover property (
        $fell(o_completion_pin) && mode_q == hbp_pkg::MODE_ASYNC
            && st_reg.is_read);
    c_async_write: cover property (
        $fell(o_completion_pin) && mode_q == hbp_pkg::MODE_ASYNC
            && !st_reg.is_read);
    c_sync_access: cover property (
        $fell(o_completion_pin) && mode_q == hbp_pkg::MODE_SYNC);
    c_ack_mode: cover property (
        $fell(o_completion_pin) && mode_q == hbp_pkg::MODE_ASYNC_ACK);
endmodule

// ---- test/hbp_host_model.sv ----
`include "hbp_defs.svh"

module hbp_host_model (
    input wire logic i_ref_clk,
    input wire logic i_done_n,
    input wire logic [7:0] i_bus,
    output logic [2:0] o_mode,
    output logic o_cs_n,
    output logic [10:0] o_addr,
    output logic o_latch,
    output logic o_rd,
    output logic o_wr,
    output logic o_hclk,
    output logic [7:0] o_data,
    output logic o_data_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_mode = 3'h0;
        o_cs_n = 1'b1;
        o_addr = 11'h000;
        o_latch = 1'b0;
        o_rd = 1'b1;
        o_wr = 1'b1;
        o_hclk = 1'b0;
        o_data = 8'h00;
        o_data_oe = 1'b0;
    end

    // host clock runs free, 40 ns period, within the sync mode limit
    always #20 o_hclk = ~o_hclk;

    task automatic access(input logic [2:0] mode, input logic rnw,
        input logic hold, input logic sel, input logic [10:0] a,
        input logic [7:0] wd, output logic [7:0] rdat, output int lat,
        output int rel, output logic ok);
        begin
            @(negedge i_ref_clk);
            o_mode = mode;
            o_addr = a;
            o_cs_n = ~sel;
            o_latch = 1'b1;
            o_wr = (mode == `HBP_MODE_CODE_ASYNC) ? 1'b1 : rnw;
            // 32 ns here; the strobe follows at least 36 ns after select
            repeat (8) @(negedge i_ref_clk);
            // hold keeps the latch pin high
            if (!hold) begin
                o_latch = 1'b0;
                repeat (2) @(negedge i_ref_clk);
                // latched address must survive later pin changes
                o_addr = {a[10:8], ~a[7:0]};
            end
            // write byte after latching, before the strobe
            o_data = wd;
            o_data_oe = ~rnw;
            if (mode == `HBP_MODE_CODE_SYNC) begin
                @(posedge o_hclk);
            end
            @(negedge i_ref_clk);
            if (mode == `HBP_MODE_CODE_ASYNC && !rnw) begin
                o_wr = 1'b0;
            end else begin
                o_rd = 1'b0;
            end
            lat = 0;
            // completion is looked at on the falling edge, where it is settled
            while (i_done_n !== 1'b0 && lat < 60) begin
                @(negedge i_ref_clk);
                lat++;
            end
            ok = (i_done_n === 1'b0);
            rdat = i_bus;
            // strobe released once completion is seen, or after 60 cycles without it
            o_rd = 1'b1;
            o_wr = 1'b1;
            rel = 0;
            while (i_done_n !== 1'b1 && rel < 20) begin
                @(negedge i_ref_clk);
                rel++;
            end
            @(negedge i_ref_clk);
            o_cs_n = 1'b1;
            o_data_oe = 1'b0;
            o_latch = 1'b0;
        end
    endtask
endmodule

// ---- test/testbench.sv ----
`include "hbp_defs.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [2:0] mode;
        logic rnw;
        logic hold;
        logic [10:0] addr;
        logic [7:0] data;
    } hbp_row_t;
    localparam logic [2:0] m_as = `HBP_MODE_CODE_ASYNC;
    localparam logic [2:0] m_sy = `HBP_MODE_CODE_SYNC;
    localparam logic [2:0] m_ak = `HBP_MODE_CODE_ASYNC_ACK;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic flip = 1'b0;
    logic [2:0] mode;
    logic cs_n;
    logic [10:0] addr;
    logic latch;
    logic rd;
    logic wr;
    logic hclk;
    logic [7:0] h_data;
    logic h_oe;
    logic [7:0] bus;
    logic [7:0] o_data;
    logic o_data_oe;
    logic done_n;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [7:0] mem [256];
    logic [7:0] exp_mem [256];
    logic ce = 1'b1;
    int oe_cnt = 0;
    int err_total = 0;
    int compares = 0;
    int wr_cnt = 0;
    int rd_cnt = 0;
    hbp_row_t rows [10];

    always #2 i_ref_clk = ~i_ref_clk;
    // a released bus shows a changing pattern, A5 and 5A on alternate cycles
    assign bus = o_data_oe ? o_data : (h_oe ? h_data : {8{flip}} ^ 8'hA5);
    assign reg_rdata = mem[reg_addr];

    always @(posedge i_ref_clk) begin
        flip <= ~flip;
        if (reg_wr === 1'b1) begin
            mem[reg_addr] <= reg_wdata;
            wr_cnt <= wr_cnt + 1;
        end
        if (reg_rd === 1'b1) begin
            rd_cnt <= rd_cnt + 1;
        end
        if (o_data_oe === 1'b1) begin
            oe_cnt <= oe_cnt + 1;
        end
    end

    hbp_host_model host (
        .i_ref_clk(i_ref_clk), .i_done_n(done_n), .i_bus(bus),
        .o_mode(mode), .o_cs_n(cs_n), .o_addr(addr), .o_latch(latch),
        .o_rd(rd), .o_wr(wr), .o_hclk(hclk), .o_data(h_data),
        .o_data_oe(h_oe)
    );

    hbp_host_port dut (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_ce(ce),
        .i_host_mode_select(mode), .i_chip_id(3'h5), .i_cs_n(cs_n),
        .i_addr(addr), .i_latch_or_start_pin(latch), .i_rd_strobe_pin(rd),
        .i_wr_rnw_pin(wr), .i_host_sync_clock(hclk), .i_data(bus),
        .o_data(o_data), .o_data_oe(o_data_oe), .o_completion_pin(done_n),
        .o_reg_addr(reg_addr), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
        .o_reg_wdata(reg_wdata), .i_reg_rdata(reg_rdata)
    );

    task automatic chk_bit(input string name, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %b seen %b", name, e, g);
            err_total++;
        end
    endtask

    task automatic chk_byte(input string name, input logic [7:0] e,
        input logic [7:0] g);
        compares++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
            err_total++;
        end
    endtask

    task test_done;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic do_reset;
        @(negedge i_ref_clk);
        i_rst_n = 1'b0;
        repeat (10) @(negedge i_ref_clk);
        chk_bit("done idle", 1'b1, done_n);
        chk_bit("oe idle", 1'b0, o_data_oe);
        chk_bit("wr idle", 1'b0, reg_wr);
        i_rst_n = 1'b1;
        repeat (3) @(negedge i_ref_clk);
    endtask

    task automatic run_row(input hbp_row_t r);
        logic [7:0] rdat;
        int lat;
        int rel;
        logic ok;
        int w0;
        int r0;
        int o0;
        w0 = wr_cnt;
        r0 = rd_cnt;
        o0 = oe_cnt;
        host.access(r.mode, r.rnw, r.hold, 1'b1, r.addr, r.data, rdat, lat,
            rel, ok);
        chk_bit("complete", 1'b1, ok);
        chk_bit("latency", 1'b1, lat <= `HBP_ACK_MAX_CYC);
        chk_bit("release", 1'b1, rel <= 5);
        chk_bit("drive", r.rnw, oe_cnt != o0);
        chk_bit("oe after", 1'b0, o_data_oe);
        chk_bit("write pulse", ~r.rnw, wr_cnt == w0 + 1);
        chk_bit("read pulse", r.rnw, rd_cnt == r0 + 1);
        if (r.rnw) begin
            chk_byte("rdata", exp_mem[r.addr[7:0]], rdat);
        end else begin
            exp_mem[r.addr[7:0]] = r.data;
            chk_byte("stored", r.data, mem[r.addr[7:0]]);
        end
    endtask

    task automatic refuse(input logic [2:0] m, input logic sel,
        input logic [10:0] a);
        logic [7:0] rdat;
        int lat;
        int rel;
        logic ok;
        int w0;
        w0 = wr_cnt;
        host.access(m, 1'b0, 1'b0, sel, a, 8'hEE, rdat, lat, rel, ok);
        chk_bit("refused", 1'b0, ok);
        chk_bit("no write", 1'b1, wr_cnt == w0);
    endtask

    initial begin
        #100000;
        err_total++;
        test_done;
    end

    initial begin
        rows = '{'{m_as, 1'b0, 1'b0, 11'h512, 8'h3C},
            '{m_as, 1'b1, 1'b0, 11'h512, 8'h00},
            '{m_as, 1'b0, 1'b1, 11'h5FF, 8'hC3},
            '{m_as, 1'b1, 1'b1, 11'h5FF, 8'h00},
            '{m_sy, 1'b0, 1'b0, 11'h500, 8'h5A},
            '{m_sy, 1'b1, 1'b0, 11'h500, 8'h00},
            '{m_ak, 1'b0, 1'b0, 11'h580, 8'hA5},
            '{m_ak, 1'b1, 1'b0, 11'h580, 8'h00},
            '{m_sy, 1'b1, 1'b0, 11'h5FF, 8'h00},
            '{m_ak, 1'b1, 1'b0, 11'h512, 8'h00}};
        do_reset();
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        refuse(m_as, 1'b0, 11'h512);
        refuse(m_as, 1'b1, 11'h212);
        for (int m = 3; m < 8; m++) begin
            refuse(3'(m), 1'b1, 11'h512);
        end
        // clock enable low: a valid strobe must be left unanswered
        ce = 1'b0;
        refuse(m_as, 1'b1, 11'h512);
        ce = 1'b1;
        run_row(rows[1]);
        do_reset();
        run_row(rows[8]);
        test_done;
    end
endmodule
